/* run_control_defs.svh */
`ifndef RUN_CONTROL_DEFS_SVH
`define RUN_CONTROL_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_MCODE       4'h8

// ----------------------------------------------------------------------
// control word bit positions
// ----------------------------------------------------------------------
`define BIT_AUTO_MODE    0
`define BIT_CYCLE_START  1
`define BIT_PAUSE        2
`define BIT_FORCED_END   3
`define BIT_SINGLE_BLOCK 4
`define BIT_JOG          5
`define BIT_MCODE_ACK    6
`define CTRL_RESET       7'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define EXCH_PERIOD_NS  1000
`define EXCH_CYCLES     (`EXCH_PERIOD_NS / `CLK_PERIOD_NS)

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* run_control_pkg.sv */
package run_control_pkg;

    typedef struct packed {
        logic mcode_ack;
        logic jog;
        logic single_block;
        logic forced_end;
        logic pause;
        logic cycle_start;
        logic auto_mode;
    } ctrl_bits_t;

    typedef enum logic [2:0] {
        ST_STOP   = 3'b000,
        ST_RUN    = 3'b001,
        ST_GAP    = 3'b010,
        ST_PAUSED = 3'b011,
        ST_MWAIT  = 3'b100
    } run_state_t;

endpackage

/* motion_program_run_control.sv */
`include "run_control_defs.svh"

// Overview of operation
// - jog taken at manual entry; start ignored
// - pause held blocks start; retoggle needed
// - pause suspends; release then rising start
// - forced end held blocks start
// - start and forced end together: end wins
// - start fall at boundary beats forced end
// - forced end aborts running block, halts
// - no restart while forced end held
// - forced end between blocks cancels next
// - pause first: forced end at start ignored
// - forced end beats simultaneous pause
// - paused: forced end ignored, start resumes
// - auto off halts, enters manual
// - paused program goes manual on auto off
// - auto off halt ignores forced end
// - forced end halt then manual on auto off
// - single block: one block per start, but M wait ack fall with start held runs the next
// - acknowledge already high skips M code
// - M wait ignores start; ack fall restarts if start held, else halts
// - forced end with ack: halt, clear M code
module motion_program_run_control #(
    parameter int MCODE_W     = 16,
    parameter int EXCH_CYCLES = `EXCH_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               srst,
    // axi4-lite slave
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // block executor side
    output logic                    block_advance,
    output logic                    block_run,
    output logic                    block_abort,
    input  wire logic               block_done,
    input  wire logic               block_has_mcode,
    input  wire logic [MCODE_W-1:0] block_mcode,
    output logic                    jog_enable,
    output logic                    manual_mode,
    output logic                    mcode_valid,
    output logic [MCODE_W-1:0]      mcode_out
);

    initial begin
        if (MCODE_W < 1 || MCODE_W > 32 || EXCH_CYCLES < 1 || EXCH_CYCLES > 65535) begin
            $error("unsupported parameter value");
        end
    end

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    run_control_pkg::ctrl_bits_t ctrl;
    run_control_pkg::run_state_t state;
    logic                        aw_held;
    logic [3:0]                  aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;

    function automatic logic known_ofs(input logic [3:0] a);
        known_ofs = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_MCODE);
    endfunction

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held      <= 1'b0;
            aw_addr      <= 4'h0;
            w_held       <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            ctrl         <= `CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_ofs(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
                // only the low lane carries the control bits
                if (aw_addr == `OFS_CTRL && w_strb[0]) begin
                    ctrl <= w_data[6:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= known_ofs(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_CTRL:   s_axi_rdata <= {25'h0, ctrl};
                `OFS_STATUS: s_axi_rdata <= {25'h0, jog_enable, block_run, mcode_valid,
                                             manual_mode, state};
                `OFS_MCODE:  s_axi_rdata <= 32'(mcode_out);
                default:     s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // exchange cycle sampling
    // ------------------------------------------------------------------
    logic [15:0]                 exch_cnt;
    logic                        tick;
    run_control_pkg::ctrl_bits_t prev;
    logic                        cs_rise;
    logic                        cs_fall;
    logic                        fe_rise;
    logic                        ack_fall;

    assign tick = (exch_cnt == 16'(EXCH_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            exch_cnt <= 16'h0000;
        end else if (tick) begin
            exch_cnt <= 16'h0000;
        end else begin
            exch_cnt <= exch_cnt + 16'h0001;
        end
    end

    // host bits are sampled into prev only on the exchange tick; manual and jog flags follow them every clock
    always_ff @(posedge clk) begin
        if (srst) begin
            prev <= `CTRL_RESET;
        end else if (tick) begin
            prev <= ctrl;
        end
    end

    assign cs_rise  = ctrl.cycle_start && !prev.cycle_start;
    assign cs_fall  = !ctrl.cycle_start && prev.cycle_start;
    assign fe_rise  = ctrl.forced_end && !prev.forced_end;
    assign ack_fall = !ctrl.mcode_ack && prev.mcode_ack;

    // ------------------------------------------------------------------
    // pending events between ticks
    // ------------------------------------------------------------------
    logic done_pend;
    logic cs_fell;

    // set wins over clear so a completion landing on the tick survives
    // a pause keeps the completion, else the resumed block never ends
    always_ff @(posedge clk) begin
        if (srst) begin
            done_pend <= 1'b0;
        end else if (block_done && block_run) begin
            done_pend <= 1'b1;
        end else if (tick && state == run_control_pkg::ST_RUN
                     && !(ctrl.auto_mode && !fe_rise && ctrl.pause)) begin
            done_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_fell <= 1'b0;
        end else if (tick && cs_fall && state == run_control_pkg::ST_RUN) begin
            cs_fell <= 1'b1;
        end else if (tick && state != run_control_pkg::ST_RUN) begin
            cs_fell <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // run sequencer
    // ------------------------------------------------------------------
    logic stop_now;

    assign stop_now = cs_fell || cs_fall;

    always_ff @(posedge clk) begin
        if (srst) begin
            state         <= run_control_pkg::ST_STOP;
            block_advance <= 1'b0;
            block_abort   <= 1'b0;
            mcode_valid   <= 1'b0;
            mcode_out     <= '0;
        end else begin
            block_advance <= 1'b0;
            block_abort   <= 1'b0;
            if (tick) begin
                case (state)
                    run_control_pkg::ST_STOP: begin
                        // manual mode ignores start; pause or forced end needs retoggle
                        if (ctrl.auto_mode && cs_rise && !ctrl.pause
                            && !ctrl.forced_end) begin
                            state         <= run_control_pkg::ST_RUN;
                            block_advance <= 1'b1;
                        end
                    end
                    run_control_pkg::ST_RUN: begin
                        if (!ctrl.auto_mode) begin
                            state <= run_control_pkg::ST_STOP;
                        end else if (fe_rise) begin
                            state       <= run_control_pkg::ST_STOP;
                            block_abort <= 1'b1;
                        end else if (ctrl.pause) begin
                            state <= run_control_pkg::ST_PAUSED;
                        end else if (done_pend) begin
                            if (block_has_mcode && !ctrl.mcode_ack) begin
                                state       <= run_control_pkg::ST_MWAIT;
                                mcode_valid <= 1'b1;
                                mcode_out   <= block_mcode;
                            end else begin
                                state <= run_control_pkg::ST_GAP;
                            end
                        end
                    end
                    run_control_pkg::ST_GAP: begin
                        if (!ctrl.auto_mode) begin
                            state <= run_control_pkg::ST_STOP;
                        end else if (stop_now) begin
                            state <= run_control_pkg::ST_STOP;
                        end else if (ctrl.forced_end) begin
                            state <= run_control_pkg::ST_STOP;
                        end else if (ctrl.single_block) begin
                            state <= run_control_pkg::ST_STOP;
                        end else begin
                            state         <= run_control_pkg::ST_RUN;
                            block_advance <= 1'b1;
                        end
                    end
                    run_control_pkg::ST_PAUSED: begin
                        // forced end is deliberately not looked at here
                        if (!ctrl.auto_mode) begin
                            state <= run_control_pkg::ST_STOP;
                        end else if (cs_rise && !ctrl.pause) begin
                            state <= run_control_pkg::ST_RUN;
                        end
                    end
                    run_control_pkg::ST_MWAIT: begin
                        if (!ctrl.auto_mode) begin
                            // code stays visible after leaving auto
                            state <= run_control_pkg::ST_STOP;
                        end else if (fe_rise) begin
                            state       <= run_control_pkg::ST_STOP;
                            block_abort <= 1'b1;
                            mcode_valid <= 1'b0;
                            mcode_out   <= '0;
                        end else if (ack_fall) begin
                            mcode_valid <= 1'b0;
                            mcode_out   <= '0;
                            if (ctrl.cycle_start) begin
                                state         <= run_control_pkg::ST_RUN;
                                block_advance <= 1'b1;
                            end else begin
                                state <= run_control_pkg::ST_STOP;
                            end
                        end
                    end
                    default: state <= run_control_pkg::ST_STOP;
                endcase
            end
        end
    end

    assign block_run = (state == run_control_pkg::ST_RUN);

    // manual flag only once no program is under way
    always_ff @(posedge clk) begin
        if (srst) begin
            manual_mode <= 1'b0;
            jog_enable  <= 1'b0;
        end else begin
            manual_mode <= !ctrl.auto_mode && state == run_control_pkg::ST_STOP;
            jog_enable  <= !ctrl.auto_mode && state == run_control_pkg::ST_STOP
                           && ctrl.jog;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    manual_start_a: assert property (tick && state == run_control_pkg::ST_STOP
        && !ctrl.auto_mode |=> state == run_control_pkg::ST_STOP && manual_mode)
        else $error("start accepted in manual mode");
    jog_manual_a: assert property (tick && state == run_control_pkg::ST_STOP
        && !ctrl.auto_mode && ctrl.jog && $stable(ctrl) |=> jog_enable)
        else $error("jog not taken in manual mode");
    pause_blocks_a: assert property (tick && state == run_control_pkg::ST_STOP
        && ctrl.pause |=> state == run_control_pkg::ST_STOP && !block_advance)
        else $error("start while pause held");
    end_blocks_a: assert property (tick && state == run_control_pkg::ST_STOP
        && ctrl.forced_end |=> state == run_control_pkg::ST_STOP)
        else $error("start while forced end held");
    pause_suspends_a: assert property (tick && block_run && ctrl.auto_mode
        && !fe_rise && ctrl.pause |=> state == run_control_pkg::ST_PAUSED && !block_run)
        else $error("pause did not suspend");
    end_aborts_a: assert property (tick && block_run && ctrl.auto_mode
        && fe_rise |=> block_abort && state == run_control_pkg::ST_STOP ##1 !block_abort)
        else $error("forced end did not abort");
    fall_wins_a: assert property (tick && state == run_control_pkg::ST_GAP
        && ctrl.auto_mode && stop_now |=> state == run_control_pkg::ST_STOP && !block_abort)
        else $error("start fall not honoured at boundary");
    gap_cancel_a: assert property (tick && state == run_control_pkg::ST_GAP
        && ctrl.auto_mode && ctrl.forced_end |=> !block_advance)
        else $error("next block launched despite forced end");
    paused_hold_a: assert property (tick && state == run_control_pkg::ST_PAUSED
        && ctrl.auto_mode && !cs_rise |=> state == run_control_pkg::ST_PAUSED)
        else $error("paused state left without start");
    auto_off_a: assert property (tick && (block_run || state == run_control_pkg::ST_PAUSED)
        && !ctrl.auto_mode |=> state == run_control_pkg::ST_STOP && !block_abort)
        else $error("auto off did not halt quietly");
    single_step_a: assert property (tick && state == run_control_pkg::ST_GAP
        && ctrl.auto_mode && !stop_now && !ctrl.forced_end && ctrl.single_block
        |=> state == run_control_pkg::ST_STOP)
        else $error("single block ran on");
    ack_skip_a: assert property (tick && block_run && ctrl.auto_mode && !fe_rise
        && !ctrl.pause && done_pend && ctrl.mcode_ack
        |=> state == run_control_pkg::ST_GAP && !mcode_valid)
        else $error("acknowledged code presented");
    mwait_hold_a: assert property (tick && state == run_control_pkg::ST_MWAIT
        && ctrl.auto_mode && !fe_rise && !ack_fall
        |=> state == run_control_pkg::ST_MWAIT && mcode_valid)
        else $error("M wait left without acknowledge fall");
    mwait_end_a: assert property (tick && state == run_control_pkg::ST_MWAIT
        && ctrl.auto_mode && fe_rise |=> !mcode_valid && state == run_control_pkg::ST_STOP)
        else $error("forced end did not clear code");
    sample_tick_a: assert property (!tick |=> $stable(prev))
        else $error("control sampled off tick");

    run_seen_c:   cover property (block_advance ##[1:300] state == run_control_pkg::ST_GAP);
    pause_seen_c: cover property (state == run_control_pkg::ST_PAUSED ##[1:300] block_run);
    mwait_seen_c: cover property (state == run_control_pkg::ST_MWAIT ##[1:300] block_advance);

endmodule

/* block_exec_model.sv */
module block_exec_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        stall,
    input  wire logic        with_mcode,
    input  wire logic [15:0] code,
    input  wire logic        block_advance,
    input  wire logic        block_run,
    input  wire logic        block_abort,
    output logic             block_done,
    output logic             block_has_mcode,
    output logic [15:0]      block_mcode,
    output logic [7:0]       blocks
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       busy;
    logic [2:0] cnt;
    // stall freezes a block so that status reads see a steady state
    always_ff @(posedge clk) begin
        block_done <= 1'b0;
        if (srst) begin
            busy <= 1'b0;
            blocks <= 8'h00;
        end else if (block_abort) begin
            busy <= 1'b0;
        end else if (block_advance) begin
            busy <= 1'b1;
            cnt <= 3'h5;
            blocks <= blocks + 8'h01;
        end else if (busy && block_run && !stall) begin
            if (cnt == 3'h0) begin
                busy <= 1'b0;
                block_done <= 1'b1;
            end else begin
                cnt <= cnt - 3'h1;
            end
        end
    end
    // no code attached: show the inverse rather than a stale value
    assign block_has_mcode = with_mcode;
    assign block_mcode     = with_mcode ? code : ~code;
endmodule

/* tb_motion_program_run_control.sv */
`include "run_control_defs.svh"
module tb_motion_program_run_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] r; logic [31:0] v; logic [31:0] m;} note_t;
    logic        clk = 1'b0, srst = 1'b1;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'hDB03;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, bdone, brun, babort, hasm;
    logic [1:0]  bresp, rresp, lastb;
    logic        advance, jog, manual, mvalid, stall = 1'b1, withm = 1'b0;
    logic [15:0] code = 16'h0, bmcode, mout;
    logic [7:0]  blocks, b0;
    int          num_errors = 0, checks_done = 0, aborts = 0;
    note_t       notes[$], nt;
    always #5 clk = ~clk;
    motion_program_run_control #(.MCODE_W(16), .EXCH_CYCLES(4)) u_motion_program_run_control (
        .clk(clk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .block_advance(advance), .block_run(brun), .block_abort(babort),
        .block_done(bdone), .block_has_mcode(hasm), .block_mcode(bmcode),
        .jog_enable(jog), .manual_mode(manual), .mcode_valid(mvalid), .mcode_out(mout));
    block_exec_model u_block_exec_model (
        .clk(clk), .srst(srst), .stall(stall), .with_mcode(withm), .code(code),
        .block_advance(advance), .block_run(brun), .block_abort(babort),
        .block_done(bdone), .block_has_mcode(hasm), .block_mcode(bmcode), .blocks(blocks));
    // ----------------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        give_verdict();
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    // every cancel pulse is counted against the scenarios that ask for one
    always @(posedge clk) begin
        if (babort === 1'b1) aborts++;
    end
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (notes.size() == 0) begin
                chk(34'h0, 34'h1);
            end else begin
                nt = notes.pop_front();
                chk({rresp, rdata & nt.m}, {nt.r, nt.v});
            end
        end
    end
    // ----------------------------------------------------------------------
    // bus master
    // ----------------------------------------------------------------------
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        lastb = bresp;
        bready <= 1'b0;
        if (n == 64) hang();
    endtask
    task automatic axr(input logic [3:0] a, input logic [1:0] r, input logic [31:0] v, m);
        int n;
        notes.push_back('{r, v, m});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 64) hang();
    endtask
    // one write, then enough exchange ticks for the block to settle
    task automatic st(input logic [6:0] c, e, input logic [6:0] m = 7'h1F);
        rnd = xorshift(rnd);
        axw(`OFS_CTRL, {rnd[31:7], c});
        repeat (24) @(posedge clk);
        axr(`OFS_STATUS, `RESP_OKAY, {25'h0, e}, {25'h0, m});
    endtask
    // ----------------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        st(7'h01, 7'h00);
        st(7'h20, 7'h48, 7'h5F);
        st(7'h22, 7'h48, 7'h5F);
        st(7'h00, 7'h08);
        $display("mode and jog done");
        st(7'h05, 7'h00);
        st(7'h07, 7'h00);
        st(7'h03, 7'h00);
        st(7'h01, 7'h00);
        st(7'h03, 7'h01);
        st(7'h07, 7'h03);
        st(7'h0F, 7'h03);
        st(7'h01, 7'h03);
        st(7'h03, 7'h01);
        st(7'h0F, 7'h00);
        st(7'h01, 7'h00);
        $display("pause done");
        st(7'h0B, 7'h00);
        st(7'h09, 7'h00);
        st(7'h0B, 7'h00);
        st(7'h01, 7'h00);
        st(7'h03, 7'h01);
        st(7'h0B, 7'h00);
        st(7'h01, 7'h00);
        st(7'h03, 7'h01);
        st(7'h0A, 7'h08);
        st(7'h0E, 7'h08);
        st(7'h01, 7'h00);
        st(7'h03, 7'h01);
        st(7'h07, 7'h03);
        st(7'h06, 7'h08);
        st(7'h01, 7'h00);
        st(7'h03, 7'h01);
        st(7'h0B, 7'h00);
        st(7'h0A, 7'h08);
        st(7'h05, 7'h00);
        st(7'h0F, 7'h00);
        $display("forced end done");
        stall <= 1'b0;
        b0 = blocks;
        st(7'h11, 7'h00);
        st(7'h13, 7'h00);
        st(7'h11, 7'h00);
        st(7'h13, 7'h00);
        chk({26'h0, blocks}, {26'h0, b0 + 8'h02});
        stall <= 1'b1;
        st(7'h11, 7'h00);
        st(7'h13, 7'h01);
        st(7'h1B, 7'h00);
        $display("single block done");
        code <= rnd[15:0];
        withm <= 1'b1;
        stall <= 1'b0;
        st(7'h41, 7'h00);
        st(7'h43, 7'h00, 7'h10);
        st(7'h41, 7'h00);
        st(7'h01, 7'h00);
        st(7'h03, 7'h14);
        axr(`OFS_MCODE, `RESP_OKAY, {16'h0, code}, 32'h0000FFFF);
        st(7'h01, 7'h14);
        st(7'h03, 7'h14);
        st(7'h43, 7'h14);
        b0 = blocks;
        st(7'h03, 7'h14);
        chk({26'h0, blocks}, {26'h0, b0 + 8'h01});
        st(7'h4B, 7'h00);
        st(7'h03, 7'h00);
        $display("code handshake done");
        axw(4'hC, 32'h0000007F);
        chk({32'h0, lastb}, {32'h0, `RESP_SLVERR});
        axr(4'hC, `RESP_SLVERR, 32'h0, 32'hFFFFFFFF);
        axr(`OFS_CTRL, `RESP_OKAY, 32'h3, 32'h7F);
        repeat (4) @(posedge clk);
        chk(34'(aborts), 34'h5);
        $display("bus done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        hang();
    end
endmodule
